// ==== include/pin_mux_defines.vh ====
// constants for the shared i/o pin function selection block
`ifndef PIN_MUX_DEFINES_VH
`define PIN_MUX_DEFINES_VH

// ****************************************************************
// geometry
// ****************************************************************
`define PIN_COUNT        8
`define REG_WIDTH        16
`define ADDR_WIDTH       4

// ****************************************************************
// register pointers
// ****************************************************************
`define PTR_GENERAL_CTRL 4'h3
`define PTR_ANALOG_IN    4'h4
`define PTR_ANALOG_OUT   4'h5
`define PTR_PULLDOWN     4'h6
`define PTR_PIN_STATUS   4'h8
`define PTR_PIN_CONFLICT 4'h9

// ****************************************************************
// reset values of the stored fields
// ****************************************************************
`define RST_ANALOG_IN    8'h00
`define RST_ANALOG_OUT   8'h00
`define RST_PULLDOWN     8'hff
`define RST_GEN_CTRL     6'h00
`define RST_CONFLICT     8'h00

// ****************************************************************
// field positions
// ****************************************************************
`define PIN_FIELD_HI     7
`define PIN_FIELD_LO     0
`define GC_FIELD_HI      9
`define GC_FIELD_LO      4
`define GC_LOCK_BIT      7
`define RESERVED_ZERO    16'h0000

`endif

// ==== design/pin_role_resolve.v ====
// per-pin role arbitration with registered pin controls
`timescale 1ns/1ps

`include "pin_mux_defines.vh"

module pin_role_resolve (
  input  wire       sys_clk,
  input  wire       rst,
  input  wire [7:0] sel_analog_in,
  input  wire [7:0] sel_analog_out,
  input  wire [7:0] sel_pulldown,
  output reg  [7:0] analog_in_en_r,
  output reg  [7:0] analog_out_en_r,
  output reg  [7:0] pulldown_en_r,
  output reg  [7:0] conflict_r
);

  // ****************************************************************
  // fixed priority: analog output, then analog input, then pull-down
  // ****************************************************************
  // the output driver wins so a pin is never driven while also being
  // loaded by the input mux or the pull-down
  wire [7:0] out_nxt;
  wire [7:0] in_nxt;
  wire [7:0] pd_nxt;
  wire [7:0] conflict_nxt;

  assign out_nxt      = sel_analog_out;
  assign in_nxt       = sel_analog_in & ~sel_analog_out;
  assign pd_nxt       = sel_pulldown & ~sel_analog_in
                        & ~sel_analog_out;
  assign conflict_nxt = (sel_analog_out & sel_analog_in)
                        | (sel_analog_out & sel_pulldown)
                        | (sel_analog_in & sel_pulldown);

  // ****************************************************************
  // registered pin controls
  // ****************************************************************
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      analog_in_en_r  <= `RST_ANALOG_IN;
      analog_out_en_r <= `RST_ANALOG_OUT;
      pulldown_en_r   <= `RST_PULLDOWN;
      conflict_r      <= `RST_CONFLICT;
    end else begin
      analog_in_en_r  <= in_nxt;
      analog_out_en_r <= out_nxt;
      pulldown_en_r   <= pd_nxt;
      conflict_r      <= conflict_nxt;
    end
  end

endmodule

// ==== design/io_pin_function_select.v ====
// pin configuration registers and role selection for eight shared pins
`timescale 1ns/1ps

`include "pin_mux_defines.vh"

module io_pin_function_select (
  input  wire        sys_clk,
  input  wire        rst,
  input  wire        reg_wr_en,
  input  wire        reg_rd_en,
  input  wire [3:0]  reg_addr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata_r,
  output reg         reg_rd_valid_r,
  output reg         reg_wr_refused_r,
  output reg         reg_addr_err_r,
  output wire [7:0]  analog_input_pin_bit,
  output wire [7:0]  analog_output_pin_bit,
  output wire [7:0]  pin_pulldown_bit,
  output wire [7:0]  pin_conflict
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  // place a stored pin field in the low byte, upper byte reads zero
  function [15:0] pin_word;
    input [7:0] field;
    begin
      pin_word = `RESERVED_ZERO;
      pin_word[`PIN_FIELD_HI:`PIN_FIELD_LO] = field;
    end
  endfunction

  // two resolved arbiter bytes side by side for the read-only status words
  function [15:0] pair_word;
    input [7:0] hi;
    input [7:0] lo;
    begin
      pair_word = {hi, lo};
    end
  endfunction

  // pointer decode shared by the write and read paths
  function is_pin_cfg;
    input [3:0] addr;
    begin
      is_pin_cfg = (addr == `PTR_ANALOG_IN)
                   || (addr == `PTR_ANALOG_OUT)
                   || (addr == `PTR_PULLDOWN);
    end
  endfunction

  function is_mapped;
    input [3:0] addr;
    begin
      is_mapped = is_pin_cfg(addr)
                  || (addr == `PTR_GENERAL_CTRL)
                  || (addr == `PTR_PIN_STATUS)
                  || (addr == `PTR_PIN_CONFLICT);
    end
  endfunction

  // ****************************************************************
  // stored configuration
  // ****************************************************************
  reg  [7:0]  analog_in_sel_r;
  reg  [7:0]  analog_in_sel_nxt;
  reg  [7:0]  analog_out_sel_r;
  reg  [7:0]  analog_out_sel_nxt;
  reg  [7:0]  pulldown_sel_r;
  reg  [7:0]  pulldown_sel_nxt;
  reg  [5:0]  gen_ctrl_r;
  reg  [5:0]  gen_ctrl_nxt;
  wire        cfg_locked;
  wire        pin_cfg_hit;
  wire        cfg_write;
  wire        ctrl_write;

  // lock bit sits at bit 7 of general control, stored from bit 4 up;
  // it is read from the stored field, so a write that sets it only
  // guards the accesses that follow
  assign cfg_locked  = gen_ctrl_r[`GC_LOCK_BIT - `GC_FIELD_LO];
  assign pin_cfg_hit = reg_wr_en && is_pin_cfg(reg_addr);
  // the lock wins over a pin word write: the word keeps its value and
  // the refusal is reported on the answer port instead
  assign cfg_write   = pin_cfg_hit && !cfg_locked;
  assign ctrl_write  = reg_wr_en && (reg_addr == `PTR_GENERAL_CTRL);

  always @* begin
    analog_in_sel_nxt  = analog_in_sel_r;
    analog_out_sel_nxt = analog_out_sel_r;
    pulldown_sel_nxt   = pulldown_sel_r;
    gen_ctrl_nxt       = gen_ctrl_r;
    if (cfg_write) begin
      case (reg_addr)
        `PTR_ANALOG_IN: begin
          // only the low byte is stored, upper bits are dropped
          analog_in_sel_nxt  =
            reg_wdata[`PIN_FIELD_HI:`PIN_FIELD_LO];
        end
        `PTR_ANALOG_OUT: begin
          analog_out_sel_nxt =
            reg_wdata[`PIN_FIELD_HI:`PIN_FIELD_LO];
        end
        `PTR_PULLDOWN: begin
          pulldown_sel_nxt   =
            reg_wdata[`PIN_FIELD_HI:`PIN_FIELD_LO];
        end
        default: begin
          // unreachable: cfg_write only fires for the three pin words
          analog_in_sel_nxt = analog_in_sel_r;
        end
      endcase
    end
    // the lock bit itself stays writable so software can release it
    if (ctrl_write) begin
      gen_ctrl_nxt = reg_wdata[`GC_FIELD_HI:`GC_FIELD_LO];
    end
  end

  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      analog_in_sel_r  <= `RST_ANALOG_IN;
      analog_out_sel_r <= `RST_ANALOG_OUT;
      pulldown_sel_r   <= `RST_PULLDOWN;
      gen_ctrl_r       <= `RST_GEN_CTRL;
    end else begin
      analog_in_sel_r  <= analog_in_sel_nxt;
      analog_out_sel_r <= analog_out_sel_nxt;
      pulldown_sel_r   <= pulldown_sel_nxt;
      gen_ctrl_r       <= gen_ctrl_nxt;
    end
  end

  // ****************************************************************
  // pin role resolution
  // ****************************************************************
  // a zero select bit simply contributes nothing to the arbiter, so
  // the pin falls through to whatever the other words ask for
  // the arbiter registers its result, so a pin changes role one edge
  // after its select word is written
  pin_role_resolve u_resolve (
    .sys_clk         (sys_clk),
    .rst             (rst),
    .sel_analog_in   (analog_in_sel_r),
    .sel_analog_out  (analog_out_sel_r),
    .sel_pulldown    (pulldown_sel_r),
    .analog_in_en_r  (analog_input_pin_bit),
    .analog_out_en_r (analog_output_pin_bit),
    .pulldown_en_r   (pin_pulldown_bit),
    .conflict_r      (pin_conflict)
  );

  // ****************************************************************
  // read path
  // ****************************************************************
  reg  [15:0] rd_word;
  reg  [15:0] gc_word;

  always @* begin
    // only the stored control field reads back, the rest reads zero
    gc_word = `RESERVED_ZERO;
    gc_word[`GC_FIELD_HI:`GC_FIELD_LO] = gen_ctrl_r;
    case (reg_addr)
      `PTR_ANALOG_IN: begin
        rd_word = pin_word(analog_in_sel_r);
      end
      `PTR_ANALOG_OUT: begin
        rd_word = pin_word(analog_out_sel_r);
      end
      `PTR_PULLDOWN: begin
        rd_word = pin_word(pulldown_sel_r);
      end
      `PTR_GENERAL_CTRL: begin
        rd_word = gc_word;
      end
      `PTR_PIN_STATUS: begin
        // roles as actually applied: output role high, input role low;
        // these trail a select write by the arbiter's extra edge
        rd_word = pair_word(analog_output_pin_bit, analog_input_pin_bit);
      end
      `PTR_PIN_CONFLICT: begin
        rd_word = pair_word(pin_pulldown_bit, pin_conflict);
      end
      default: begin
        rd_word = `RESERVED_ZERO;
      end
    endcase
  end

  // ****************************************************************
  // access answers
  // ****************************************************************
  // reads answer one edge after the request; a read in the same cycle
  // as a write returns the value from before that write
  always @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_r      <= `RESERVED_ZERO;
      reg_rd_valid_r   <= 1'b0;
      reg_wr_refused_r <= 1'b0;
      reg_addr_err_r   <= 1'b0;
    end else begin
      reg_rd_valid_r   <= reg_rd_en;
      if (reg_rd_en) begin
        reg_rdata_r <= rd_word;
      end
      reg_wr_refused_r <= pin_cfg_hit && cfg_locked;
      // an unmapped read is still answered, with a zero word
      reg_addr_err_r   <= (reg_wr_en || reg_rd_en)
                          && !is_mapped(reg_addr);
    end
  end

endmodule

// ==== dv/io_pin_function_select_checker.sv ====
// assertion checker for the pin function selection block
`timescale 1ns/1ps
module io_pin_function_select_checker (
  input wire logic        sys_clk,
  input wire logic        rst,
  input wire logic        reg_wr_en,
  input wire logic        reg_rd_en,
  input wire logic [3:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata_r,
  input wire logic        reg_rd_valid_r,
  input wire logic        reg_wr_refused_r,
  input wire logic        reg_addr_err_r,
  input wire logic [7:0]  analog_input_pin_bit,
  input wire logic [7:0]  analog_output_pin_bit,
  input wire logic [7:0]  pin_pulldown_bit,
  input wire logic [7:0]  pin_conflict
);
  reg        lock_r;
  wire       wr_pin = reg_wr_en && reg_addr >= 4'h4 && reg_addr <= 4'h6;
  wire       mapped = (reg_addr >= 4'h3 && reg_addr <= 4'h6) ||
                      reg_addr == 4'h8 || reg_addr == 4'h9;
  wire [7:0] claimed = analog_output_pin_bit | analog_input_pin_bit;
  // shadow of the lock bit, needed to know which writes must be refused
  always @(posedge sys_clk or posedge rst) begin
    if (rst)
      lock_r <= 1'b0;
    else if (reg_wr_en && reg_addr == 4'h3)
      lock_r <= reg_wdata[7];
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  rd_answer_a: assert property (reg_rd_valid_r == $past(reg_rd_en))
    else $error("read valid does not follow read request");
  lock_refuse_a: assert property (
    reg_wr_refused_r == $past(wr_pin && lock_r))
    else $error("refused pulse wrong for lock state");
  addr_err_a: assert property (
    reg_addr_err_r == $past((reg_wr_en || reg_rd_en) && !mapped))
    else $error("address error pulse wrong");
  rsvd_zero_a: assert property (
    reg_rd_valid_r && $past(reg_addr) >= 4'h4 && $past(reg_addr) <= 4'h6
    |-> reg_rdata_r[15:8] == 8'h00)
    else $error("reserved byte of a pin word reads nonzero");
  out_follow_a: assert property (
    reg_wr_en && reg_addr == 4'h5 && !lock_r
    |-> ##2 analog_output_pin_bit == $past(reg_wdata[7:0], 2))
    else $error("output role does not follow its select word");
  in_follow_a: assert property (
    reg_wr_en && reg_addr == 4'h4 && !lock_r |-> ##2
    analog_input_pin_bit ==
      ($past(reg_wdata[7:0], 2) & ~analog_output_pin_bit))
    else $error("input role does not follow its select word");
  pd_follow_a: assert property (
    reg_wr_en && reg_addr == 4'h6 && !lock_r
    |-> ##2 pin_pulldown_bit == ($past(reg_wdata[7:0], 2) & ~claimed))
    else $error("pull-down role does not follow its select word");
  role_excl_a: assert property (
    (analog_output_pin_bit & analog_input_pin_bit) == 8'h00 &&
    (pin_pulldown_bit & claimed) == 8'h00)
    else $error("a pin holds two roles at once");
  conflict_won_a: assert property (
    (pin_conflict & ~claimed) == 8'h00)
    else $error("conflicting pin not won by a converter role");
  cover property (reg_wr_refused_r);
  cover property (pin_conflict != 8'h00);
  cover property (reg_addr_err_r);
endmodule
bind io_pin_function_select io_pin_function_select_checker
  io_pin_function_select_checker_i (.sys_clk(sys_clk), .rst(rst),
  .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata_r(reg_rdata_r),
  .reg_rd_valid_r(reg_rd_valid_r), .reg_wr_refused_r(reg_wr_refused_r),
  .reg_addr_err_r(reg_addr_err_r),
  .analog_input_pin_bit(analog_input_pin_bit),
  .analog_output_pin_bit(analog_output_pin_bit),
  .pin_pulldown_bit(pin_pulldown_bit), .pin_conflict(pin_conflict));

// ==== dv/tb_top.sv ====
// self-checking bench for the pin function selection block
`timescale 1ns/1ps
module tb_top;
  reg         sys_clk = 1'b0;
  reg         rst = 1'b1;
  reg         reg_wr_en = 1'b0;
  reg         reg_rd_en = 1'b0;
  reg  [3:0]  reg_addr = 4'h0;
  reg  [15:0] reg_wdata = 16'h0000;
  wire [15:0] rdata;
  wire        rd_valid;
  wire        refused;
  wire        addr_err;
  wire [7:0]  ain;
  wire [7:0]  aout;
  wire [7:0]  pd;
  wire [7:0]  conf;
  integer     n_mismatch = 0;
  integer     compares = 0;
  integer     seed = 15511;
  integer     cycles = 0;
  integer     i;
  reg  [31:0] r;
  reg  [3:0]  a;
  reg  [7:0]  si;
  reg  [7:0]  so;
  reg  [7:0]  sp;
  reg  [5:0]  gc;
  always #2.5 sys_clk = ~sys_clk;
  io_pin_function_select io_pin_function_select_i (.sys_clk(sys_clk),
    .rst(rst), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(rdata),
    .reg_rd_valid_r(rd_valid), .reg_wr_refused_r(refused),
    .reg_addr_err_r(addr_err), .analog_input_pin_bit(ain),
    .analog_output_pin_bit(aout), .pin_pulldown_bit(pd),
    .pin_conflict(conf));
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      n_mismatch = n_mismatch + 1;
      give_verdict;
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("ERROR at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // status words are only meaningful once the role flops have settled
  function [15:0] model_rd(input [3:0] ad);
    case (ad)
      4'h3: model_rd = {6'h00, gc, 4'h0};
      4'h4: model_rd = {8'h00, si};
      4'h5: model_rd = {8'h00, so};
      4'h6: model_rd = {8'h00, sp};
      4'h8: model_rd = {so, si & ~so};
      4'h9: model_rd = {sp & ~so & ~si, (si & so) | (si & sp) | (so & sp)};
      default: model_rd = 16'h0000;
    endcase
  endfunction
  task op(input we, input re, input [3:0] ad, input [15:0] d);
    reg [15:0] exp;
    reg        locked;
    exp = model_rd(ad);
    locked = gc[3] && ad >= 4'h4 && ad <= 4'h6;
    reg_wr_en = we;
    reg_rd_en = re;
    reg_addr = ad;
    reg_wdata = d;
    @(posedge sys_clk);
    #1;
    chk(rd_valid, re);
    if (re) chk(rdata, exp);
    chk(refused, we && locked);
    chk(addr_err, (we || re) && (ad < 4'h3 || ad == 4'h7 || ad > 4'h9));
    if (we && !locked) begin
      case (ad)
        4'h3: gc = d[9:4];
        4'h4: si = d[7:0];
        4'h5: so = d[7:0];
        4'h6: sp = d[7:0];
        default: ;
      endcase
    end
  endtask
  task pins;
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk({aout, ain}, model_rd(4'h8));
    chk({pd, conf}, model_rd(4'h9));
    op(1'b0, 1'b1, 4'h8, 16'h0000);
    op(1'b0, 1'b1, 4'h9, 16'h0000);
  endtask
  initial begin
    si = 8'h00;
    so = 8'h00;
    sp = 8'hff;
    gc = 6'h00;
    repeat (16) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    pins;
    for (i = 3; i < 8; i = i + 1) op(1'b0, 1'b1, i[3:0], 16'h0000);
    $display("test reset_values done");
    op(1'b1, 1'b0, 4'h3, 16'hffff);
    for (i = 4; i < 7; i = i + 1) op(1'b1, 1'b1, i[3:0], 16'h5a5a);
    op(1'b1, 1'b0, 4'h3, 16'h0000);
    op(1'b1, 1'b0, 4'h8, 16'hffff);
    op(1'b1, 1'b0, 4'h9, 16'hffff);
    pins;
    $display("test lock done");
    for (i = 0; i < 24; i = i + 1) begin
      a = {2'b01, i[4:3]};
      op(1'b1, 1'b0, a, 16'hff00 | (16'h0001 << i[2:0]));
      pins;
    end
    $display("test walking_bits done");
    // back-to-back random traffic; status words skipped while roles settle
    for (i = 0; i < 200; i = i + 1) begin
      r = $random(seed);
      a = r[3:0];
      if (a == 4'h8 || a == 4'h9) a = 4'h6;
      op(r[4], r[5], a, r[31:16]);
    end
    pins;
    $display("test random_traffic done");
    // requests idle across the reset so no answer spans it
    reg_rd_en = 1'b0;
    @(posedge sys_clk);
    #1;
    rst = 1'b1;
    si = 8'h00;
    so = 8'h00;
    sp = 8'hff;
    gc = 6'h00;
    repeat (2) @(posedge sys_clk);
    #1;
    rst = 1'b0;
    pins;
    op(1'b0, 1'b1, 4'h3, 16'h0000);
    $display("test mid_reset done");
    give_verdict;
  end
endmodule
